// ### src/flash_stat_pkg.sv
/*
 flash status and fault interrupt enable register bank: shared constants and types.
 assumes: used by the register bank top and by the testbench.
*/
package flash_stat_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [3:0] IDX_FAULT_IRQ_ENABLE = 4'h5;
    localparam logic [3:0] IDX_FLASH_STATUS = 4'h6;
    localparam logic [3:0] IDX_FAULT_STATUS = 4'h7;
    localparam logic [3:0] IDX_CONFIG = 4'h4;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
    localparam logic [7:0] ADDR_FAULT_IRQ_ENABLE = {2'b00, IDX_FAULT_IRQ_ENABLE, 2'b00};
    localparam logic [7:0] ADDR_FLASH_STATUS = {2'b00, IDX_FLASH_STATUS, 2'b00};
    localparam logic [7:0] ADDR_FAULT_STATUS = {2'b00, IDX_FAULT_STATUS, 2'b00};
    localparam logic [7:0] ADDR_CONFIG = {2'b00, IDX_CONFIG, 2'b00};
    localparam logic [7:0] ADDR_IRQ_STATUS = {2'b00, IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] ADDR_IRQ_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};

    // field positions
    localparam int BIT_SINGLE_FAULT = 0;
    localparam int BIT_DOUBLE_FAULT = 1;
    localparam int BIT_BUSY = 3;
    localparam int BIT_PROT_VIOL = 4;
    localparam int BIT_ACC_ERR = 5;
    localparam int BIT_CMD_COMPLETE = 7;
    localparam int BIT_SUPPRESS_SF = 4;

    // reset values
    localparam logic [7:0] RST_FAULT_IRQ_ENABLE = 8'h00;
    localparam logic [1:0] RST_COMPLETION = 2'b00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [2:0] RST_IRQ_MASK = 3'b000;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // events from the flash core
    typedef struct packed {
        logic cmd_done;
        logic acc_err;
        logic prot_viol;
        logic double_fault;
        logic single_fault;
        logic array_read_invalid;
        logic [1:0] completion;
    } core_event_s;

    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_BUSY
    } cmd_state_e;

endpackage

// ### src/flash_status_error_enable_regs.sv
/*
 flash status and fault interrupt enable registers with an axi4-lite slave.
 assumes: core event inputs come from logic on CLK_SYS and are one-cycle pulses;
 the command engine takes CMD_LAUNCH and later pulses cmd_done.
*/
`timescale 1ns/10ps
module flash_status_error_enable_regs (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // axi4-lite write
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // flash core events
    input wire flash_stat_pkg::core_event_s CORE_EVT,
    input wire logic INIT_DONE,
    input wire logic [1:0] INIT_COMPLETION,
    // command engine
    output logic CMD_LAUNCH,
    output logic SEQ_ALLOWED,
    output logic BUSY,
    // interrupts
    output logic IRQ_CMD_COMPLETE,
    output logic IRQ_DOUBLE_FAULT,
    output logic IRQ_SINGLE_FAULT,
    output logic IRQ
);

    logic [7:0] aw_addr_reg, wb;
    logic aw_have_reg, w_have_reg, wr_go, bvalid_reg, rvalid_reg;
    logic awready_reg, wready_reg, arready_reg;
    logic [31:0] w_data_reg, rdata_reg, rdata_next;
    logic [3:0] w_strb_reg;
    logic [1:0] rresp_reg, bresp_reg, bresp_next, rresp_next;

    logic [1:0] fault_irq_enable_reg, completion_status_bits_reg;
    logic [7:0] config_reg, flash_status;
    logic cmd_complete_flag_reg, access_error_flag_reg, protection_violation_flag_reg;
    logic double_fault_flag_reg, single_fault_flag_reg, launch_req, init_seen_reg;
    logic [2:0] irq_status_reg, irq_mask_reg;
    flash_stat_pkg::cmd_state_e cmd_state_reg;

    // write channel capture
    assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wb = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            aw_have_reg <= 1'b0;
            awready_reg <= 1'b1;
            aw_addr_reg <= 8'h00;
        end else if (S_AXI_AWVALID && !aw_have_reg) begin
            aw_have_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_addr_reg <= S_AXI_AWADDR;
        end else if (wr_go) begin
            aw_have_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            w_have_reg <= 1'b0;
            wready_reg <= 1'b1;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (S_AXI_WVALID && !w_have_reg) begin
            w_have_reg <= 1'b1;
            wready_reg <= 1'b0;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end else if (wr_go) begin
            w_have_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    always_comb begin
        if (aw_addr_reg == flash_stat_pkg::ADDR_FAULT_IRQ_ENABLE ||
            aw_addr_reg == flash_stat_pkg::ADDR_FLASH_STATUS ||
            aw_addr_reg == flash_stat_pkg::ADDR_FAULT_STATUS ||
            aw_addr_reg == flash_stat_pkg::ADDR_CONFIG ||
            aw_addr_reg == flash_stat_pkg::ADDR_IRQ_STATUS ||
            aw_addr_reg == flash_stat_pkg::ADDR_IRQ_MASK) begin
            bresp_next = flash_stat_pkg::RESP_OKAY;
        end else begin
            bresp_next = flash_stat_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= flash_stat_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= bresp_next;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_go && aw_addr_reg == a && w_strb_reg[0];
    endfunction

    // enable and config registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            fault_irq_enable_reg <= flash_stat_pkg::RST_FAULT_IRQ_ENABLE[1:0];
        end else if (wr_hit(flash_stat_pkg::ADDR_FAULT_IRQ_ENABLE)) begin
            fault_irq_enable_reg <= wb[1:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            config_reg <= flash_stat_pkg::RST_CONFIG;
        end else if (wr_hit(flash_stat_pkg::ADDR_CONFIG)) begin
            config_reg <= {wb[7], 2'b00, wb[4], 4'h0};
        end
    end

    // command launch
    assign launch_req = wr_hit(flash_stat_pkg::ADDR_FLASH_STATUS) &&
        wb[flash_stat_pkg::BIT_CMD_COMPLETE] && cmd_complete_flag_reg &&
        !access_error_flag_reg && !protection_violation_flag_reg &&
        !(wb[flash_stat_pkg::BIT_ACC_ERR] || wb[flash_stat_pkg::BIT_PROT_VIOL]) ?
        1'b1 : 1'b0;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cmd_state_reg <= flash_stat_pkg::CMD_IDLE;
            cmd_complete_flag_reg <= 1'b1;
        end else begin
            case (cmd_state_reg)
                flash_stat_pkg::CMD_IDLE: begin
                    if (launch_req) begin
                        cmd_state_reg <= flash_stat_pkg::CMD_BUSY;
                        cmd_complete_flag_reg <= 1'b0;
                    end
                end
                default: begin
                    if (CORE_EVT.cmd_done || CORE_EVT.acc_err || CORE_EVT.prot_viol) begin
                        cmd_state_reg <= flash_stat_pkg::CMD_IDLE;
                        cmd_complete_flag_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // sticky error flags, set wins over clear
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            access_error_flag_reg <= 1'b0;
            protection_violation_flag_reg <= 1'b0;
        end else begin
            if (CORE_EVT.acc_err) begin
                access_error_flag_reg <= 1'b1;
            end else if (wr_hit(flash_stat_pkg::ADDR_FLASH_STATUS) &&
                         wb[flash_stat_pkg::BIT_ACC_ERR]) begin
                access_error_flag_reg <= 1'b0;
            end
            if (CORE_EVT.prot_viol) begin
                protection_violation_flag_reg <= 1'b1;
            end else if (wr_hit(flash_stat_pkg::ADDR_FLASH_STATUS) &&
                         wb[flash_stat_pkg::BIT_PROT_VIOL]) begin
                protection_violation_flag_reg <= 1'b0;
            end
        end
    end

    // completion status, loaded once by the reset-time init sequence, cleared on launch, reloaded on cmd_done
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            completion_status_bits_reg <= flash_stat_pkg::RST_COMPLETION;
            init_seen_reg <= 1'b0;
        end else if (INIT_DONE && !init_seen_reg) begin
            init_seen_reg <= 1'b1;
            completion_status_bits_reg <= INIT_COMPLETION;
        end else if (launch_req) begin
            completion_status_bits_reg <= flash_stat_pkg::RST_COMPLETION;
        end else if (CORE_EVT.cmd_done) begin
            completion_status_bits_reg <= CORE_EVT.completion;
        end
    end

    // ecc fault flags
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            double_fault_flag_reg <= 1'b0;
            single_fault_flag_reg <= 1'b0;
        end else begin
            if (CORE_EVT.double_fault || CORE_EVT.array_read_invalid) begin
                double_fault_flag_reg <= 1'b1;
            end else if (wr_hit(flash_stat_pkg::ADDR_FAULT_STATUS) &&
                         wb[flash_stat_pkg::BIT_DOUBLE_FAULT]) begin
                double_fault_flag_reg <= 1'b0;
            end
            if (!config_reg[flash_stat_pkg::BIT_SUPPRESS_SF] &&
                (CORE_EVT.single_fault || CORE_EVT.array_read_invalid)) begin
                single_fault_flag_reg <= 1'b1;
            end else if (wr_hit(flash_stat_pkg::ADDR_FAULT_STATUS) &&
                         wb[flash_stat_pkg::BIT_SINGLE_FAULT]) begin
                single_fault_flag_reg <= 1'b0;
            end
        end
    end

    // status byte, busy mirrors command state
    assign flash_status = {cmd_complete_flag_reg, 1'b0, access_error_flag_reg,
        protection_violation_flag_reg, !cmd_complete_flag_reg, 1'b0,
        completion_status_bits_reg};

    // interrupt outputs
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            IRQ_CMD_COMPLETE <= 1'b0;
            IRQ_DOUBLE_FAULT <= 1'b0;
            IRQ_SINGLE_FAULT <= 1'b0;
        end else begin
            IRQ_CMD_COMPLETE <= cmd_complete_flag_reg && config_reg[7];
            IRQ_DOUBLE_FAULT <= double_fault_flag_reg &&
                fault_irq_enable_reg[flash_stat_pkg::BIT_DOUBLE_FAULT];
            IRQ_SINGLE_FAULT <= single_fault_flag_reg &&
                fault_irq_enable_reg[flash_stat_pkg::BIT_SINGLE_FAULT];
        end
    end

    // sticky event status, write one to clear; mask gates IRQ
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            irq_status_reg <= 3'b000;
            irq_mask_reg <= flash_stat_pkg::RST_IRQ_MASK;
            IRQ <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg &
                ~(wr_hit(flash_stat_pkg::ADDR_IRQ_STATUS) ? wb[2:0] : 3'b000)) |
                {CORE_EVT.cmd_done, CORE_EVT.acc_err, CORE_EVT.prot_viol};
            if (wr_hit(flash_stat_pkg::ADDR_IRQ_MASK)) begin
                irq_mask_reg <= wb[2:0];
            end
            IRQ <= |(irq_status_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            CMD_LAUNCH <= 1'b0;
            SEQ_ALLOWED <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            CMD_LAUNCH <= launch_req;
            SEQ_ALLOWED <= !protection_violation_flag_reg && cmd_complete_flag_reg;
            BUSY <= !cmd_complete_flag_reg;
        end
    end

    // read channel
    always_comb begin
        rresp_next = flash_stat_pkg::RESP_OKAY;
        if (S_AXI_ARADDR == flash_stat_pkg::ADDR_FAULT_IRQ_ENABLE) begin
            rdata_next = {30'h0000_0000, fault_irq_enable_reg};
        end else if (S_AXI_ARADDR == flash_stat_pkg::ADDR_FLASH_STATUS) begin
            rdata_next = {24'h00_0000, flash_status};
        end else if (S_AXI_ARADDR == flash_stat_pkg::ADDR_FAULT_STATUS) begin
            rdata_next = {30'h0000_0000, double_fault_flag_reg, single_fault_flag_reg};
        end else if (S_AXI_ARADDR == flash_stat_pkg::ADDR_CONFIG) begin
            rdata_next = {24'h00_0000, config_reg};
        end else if (S_AXI_ARADDR == flash_stat_pkg::ADDR_IRQ_STATUS) begin
            rdata_next = {29'h0000_0000, irq_status_reg};
        end else if (S_AXI_ARADDR == flash_stat_pkg::ADDR_IRQ_MASK) begin
            rdata_next = {29'h0000_0000, irq_mask_reg};
        end else begin
            rdata_next = 32'h0000_0000;
            rresp_next = flash_stat_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= flash_stat_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            arready_reg <= 1'b0;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

    // checks
    property p_double_irq;
        @(posedge CLK_SYS) disable iff (!RST_N)
        double_fault_flag_reg && fault_irq_enable_reg[1] |=> IRQ_DOUBLE_FAULT;
    endproperty
    a_double_irq: assert property (p_double_irq) else $error("double irq missing");

    property p_single_irq_off;
        @(posedge CLK_SYS) disable iff (!RST_N)
        !fault_irq_enable_reg[0] |=> !IRQ_SINGLE_FAULT;
    endproperty
    a_single_irq_off: assert property (p_single_irq_off) else $error("single irq leak");

    property p_launch_clears;
        @(posedge CLK_SYS) disable iff (!RST_N)
        launch_req |=> !cmd_complete_flag_reg ##1 BUSY;
    endproperty
    a_launch_clears: assert property (p_launch_clears) else $error("launch not seen");

    property p_acc_blocks;
        @(posedge CLK_SYS) disable iff (!RST_N)
        access_error_flag_reg && cmd_complete_flag_reg |=> cmd_complete_flag_reg;
    endproperty
    a_acc_blocks: assert property (p_acc_blocks) else $error("launch under error");

    property p_acc_set;
        @(posedge CLK_SYS) disable iff (!RST_N)
        CORE_EVT.acc_err |=> access_error_flag_reg;
    endproperty
    a_acc_set: assert property (p_acc_set) else $error("access error lost");

    property p_prot_hold;
        @(posedge CLK_SYS) disable iff (!RST_N)
        protection_violation_flag_reg && !(wr_hit(flash_stat_pkg::ADDR_FLASH_STATUS)
            && wb[4]) |=> protection_violation_flag_reg;
    endproperty
    a_prot_hold: assert property (p_prot_hold) else $error("violation dropped");

    property p_busy;
        @(posedge CLK_SYS) disable iff (!RST_N)
        BUSY == !$past(cmd_complete_flag_reg);
    endproperty
    a_busy: assert property (p_busy) else $error("busy mismatch");

    property p_double_set;
        @(posedge CLK_SYS) disable iff (!RST_N)
        CORE_EVT.double_fault |=> double_fault_flag_reg;
    endproperty
    a_double_set: assert property (p_double_set) else $error("double fault lost");

    c_launch: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        launch_req ##[1:50] cmd_complete_flag_reg);
    c_acc: cover property (@(posedge CLK_SYS) disable iff (!RST_N) CORE_EVT.acc_err);
    c_irq: cover property (@(posedge CLK_SYS) disable iff (!RST_N) IRQ_DOUBLE_FAULT);

endmodule

// ### tb/tb.sv
/*
 self-checking bench for the flash status and fault interrupt enable register bank.
 assumes: the design files under src/ are compiled first; the bench stands in for
 the cpu on axi4-lite and for the flash core on the event inputs.
*/
`timescale 1ns/10ps
module tb;
    logic CLK_SYS = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00;
    logic S_AXI_AWVALID = 1'b0;
    logic S_AXI_AWREADY;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000;
    logic [3:0] S_AXI_WSTRB = 4'h0;
    logic S_AXI_WVALID = 1'b0;
    logic S_AXI_WREADY;
    logic [1:0] S_AXI_BRESP;
    logic S_AXI_BVALID;
    logic S_AXI_BREADY = 1'b0;
    logic [7:0] S_AXI_ARADDR = 8'h00;
    logic S_AXI_ARVALID = 1'b0;
    logic S_AXI_ARREADY;
    logic [31:0] S_AXI_RDATA;
    logic [1:0] S_AXI_RRESP;
    logic S_AXI_RVALID;
    logic S_AXI_RREADY = 1'b0;
    flash_stat_pkg::core_event_s CORE_EVT = '0;
    logic INIT_DONE = 1'b0;
    logic [1:0] INIT_COMPLETION = 2'h0;
    logic CMD_LAUNCH, SEQ_ALLOWED, BUSY;
    logic IRQ_CMD_COMPLETE, IRQ_DOUBLE_FAULT, IRQ_SINGLE_FAULT, IRQ;
    int errors = 0;
    int num_checks = 0;
    int launches = 0;
    int n;
    logic [1:0] resp;
    logic [31:0] rdat;

    flash_status_error_enable_regs dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
        .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
        .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .CORE_EVT(CORE_EVT),
        .INIT_DONE(INIT_DONE), .INIT_COMPLETION(INIT_COMPLETION), .CMD_LAUNCH(CMD_LAUNCH),
        .SEQ_ALLOWED(SEQ_ALLOWED), .BUSY(BUSY), .IRQ_CMD_COMPLETE(IRQ_CMD_COMPLETE),
        .IRQ_DOUBLE_FAULT(IRQ_DOUBLE_FAULT), .IRQ_SINGLE_FAULT(IRQ_SINGLE_FAULT), .IRQ(IRQ));

    always #2.5 CLK_SYS = ~CLK_SYS;

    // count launch pulses
    always @(posedge CLK_SYS) begin
        if (CMD_LAUNCH === 1'b1) begin
            launches <= launches + 1;
        end
    end

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_bit(input string name, input logic e, input logic g);
        chk(name, {31'h0, e}, {31'h0, g});
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge CLK_SYS);
        #1;
    endtask

    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge CLK_SYS);
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= 4'hF;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge CLK_SYS);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                S_AXI_AWVALID <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                S_AXI_WVALID <= 1'b0;
            end
            if (S_AXI_BVALID === 1'b1) begin
                resp = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
                break;
            end
        end
        if (k == 100) begin
            errors++;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge CLK_SYS);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge CLK_SYS);
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARVALID <= 1'b0;
            end
            if (S_AXI_RVALID === 1'b1) begin
                rdat = S_AXI_RDATA;
                resp = S_AXI_RRESP;
                S_AXI_RREADY <= 1'b0;
                break;
            end
        end
        if (k == 100) begin
            errors++;
        end
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(name, e, rdat);
        chk("rresp", 32'h0000_0000, {30'h0, resp});
    endtask

    // one-cycle core event, msb first: done, acc, prot, dbl, sgl, inv, completion
    task automatic pulse(input logic [7:0] v);
        @(posedge CLK_SYS);
        CORE_EVT <= flash_stat_pkg::core_event_s'(v);
        @(posedge CLK_SYS);
        CORE_EVT <= '0;
        settle(3);
    endtask

    task automatic t_reset;
        rchk("fault_irq_enable", 8'h14, 32'h0000_0000);
        rchk("flash_status", 8'h18, 32'h0000_0080);
        @(posedge CLK_SYS);
        INIT_COMPLETION <= 2'h2;
        INIT_DONE <= 1'b1;
        @(posedge CLK_SYS);
        INIT_DONE <= 1'b0;
        rchk("flash_status", 8'h18, 32'h0000_0082);
    endtask

    task automatic t_fault_irq;
        wr(8'h14, 32'h0000_00FF);
        rchk("fault_irq_enable", 8'h14, 32'h0000_0003);
        wr(8'h14, 32'h0000_0000);
        pulse(8'h10);
        rchk("fault_status", 8'h1C, 32'h0000_0002);
        chk_bit("irq_double_fault", 1'b0, IRQ_DOUBLE_FAULT);
        wr(8'h14, 32'h0000_0002);
        settle(2);
        chk_bit("irq_double_fault", 1'b1, IRQ_DOUBLE_FAULT);
        wr(8'h1C, 32'h0000_0000);
        settle(2);
        chk_bit("irq_double_fault", 1'b1, IRQ_DOUBLE_FAULT);
        wr(8'h1C, 32'h0000_0002);
        settle(2);
        chk_bit("irq_double_fault", 1'b0, IRQ_DOUBLE_FAULT);
        wr(8'h10, 32'h0000_0010);
        pulse(8'h08);
        rchk("fault_status", 8'h1C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0000);
        pulse(8'h08);
        rchk("fault_status", 8'h1C, 32'h0000_0001);
        wr(8'h14, 32'h0000_0003);
        settle(2);
        chk_bit("irq_single_fault", 1'b1, IRQ_SINGLE_FAULT);
        wr(8'h14, 32'h0000_0002);
        settle(2);
        chk_bit("irq_single_fault", 1'b0, IRQ_SINGLE_FAULT);
        wr(8'h1C, 32'h0000_0001);
        pulse(8'h04);
        rchk("fault_status", 8'h1C, 32'h0000_0003);
        wr(8'h1C, 32'h0000_0003);
        wr(8'h14, 32'h0000_0000);
    endtask

    task automatic t_launch;
        wr(8'h10, 32'h0000_0080);
        settle(2);
        chk_bit("irq_cmd_complete", 1'b1, IRQ_CMD_COMPLETE);
        n = launches;
        wr(8'h18, 32'h0000_0080);
        settle(2);
        chk("launches", n + 1, launches);
        chk_bit("busy", 1'b1, BUSY);
        chk_bit("seq_allowed", 1'b0, SEQ_ALLOWED);
        chk_bit("irq_cmd_complete", 1'b0, IRQ_CMD_COMPLETE);
        rchk("flash_status", 8'h18, 32'h0000_0008);
        pulse(8'h81);
        rchk("flash_status", 8'h18, 32'h0000_0081);
        chk_bit("busy", 1'b0, BUSY);
        chk_bit("irq_cmd_complete", 1'b1, IRQ_CMD_COMPLETE);
        wr(8'h10, 32'h0000_0000);
    endtask

    task automatic t_errors;
        pulse(8'h40);
        rchk("flash_status", 8'h18, 32'h0000_00A1);
        n = launches;
        wr(8'h18, 32'h0000_0080);
        settle(2);
        chk("launches", n, launches);
        wr(8'h18, 32'h0000_0000);
        rchk("flash_status", 8'h18, 32'h0000_00A1);
        wr(8'h18, 32'h0000_0020);
        rchk("flash_status", 8'h18, 32'h0000_0081);
        wr(8'h24, 32'h0000_0001);
        wr(8'h18, 32'h0000_0080);
        pulse(8'h20);
        rchk("flash_status", 8'h18, 32'h0000_0090);
        chk_bit("seq_allowed", 1'b0, SEQ_ALLOWED);
        chk_bit("irq", 1'b1, IRQ);
        n = launches;
        wr(8'h18, 32'h0000_0080);
        settle(2);
        chk("launches", n, launches);
        wr(8'h18, 32'h0000_0000);
        rchk("flash_status", 8'h18, 32'h0000_0090);
        wr(8'h20, 32'h0000_0001);
        settle(2);
        chk_bit("irq", 1'b0, IRQ);
        wr(8'h18, 32'h0000_0010);
        rchk("flash_status", 8'h18, 32'h0000_0080);
        chk_bit("seq_allowed", 1'b1, SEQ_ALLOWED);
        wr(8'h24, 32'h0000_0000);
    endtask

    task automatic t_readonly;
        wr(8'h18, 32'h0000_000F);
        rchk("flash_status", 8'h18, 32'h0000_0080);
        wr(8'h3C, 32'h0000_00FF);
        chk("bresp", 32'h0000_0002, {30'h0, resp});
        rd(8'h3C);
        chk("rdata", 32'h0000_0000, rdat);
        chk("rresp", 32'h0000_0002, {30'h0, resp});
    endtask

    task automatic finish_test;
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        t_reset();
        t_fault_irq();
        t_launch();
        t_errors();
        t_readonly();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge CLK_SYS);
        errors++;
        finish_test();
    end
endmodule
